// File: rtl/pfl_flags.sv
// module: processor flag register with privilege checks, step trap and string stepping
`timescale 1ns/10ps
// Functional notes
// - io allowed when privilege within io level
// - pop changes interrupt enable only if permitted
// - pops alter io level only at privilege 0
// - task switch always loads io level
// - overflow flag: carry into xor out of msb
// - overflow taken at bit 7, 15, 31
// - direction flag steers index increment or decrement
// - maskable interrupt recognised only when enabled
// - single step flag traps after next instruction
// - otherwise trap only on breakpoint match
// - sign flag copies result msb
// - zero flag set on all-zero result
// - half carry from bit 3
// - parity even over low eight bits
module pfl_flags
  import pfl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_protected_mode,
  input wire logic [1:0] i_current_privilege_level,
  input wire logic i_alu_valid,
  input wire logic [31:0] i_alu_a,
  input wire logic [31:0] i_alu_b,
  input wire logic i_alu_cin,
  input wire pfl_op_t i_alu_op,
  input wire pfl_size_t i_alu_size,
  input wire pfl_load_t i_load_kind,
  input wire logic [31:0] i_load_image,
  input wire logic i_string_step,
  input wire pfl_size_t i_string_size,
  input wire logic [31:0] i_string_source_index,
  input wire logic [31:0] i_string_dest_index,
  input wire logic i_maskable_interrupt_pin,
  input wire logic i_insn_done,
  input wire logic i_breakpoint_hit,
  output logic [31:0] o_processor_flags_register,
  output logic [31:0] o_alu_result,
  output logic o_io_allowed,
  output logic [31:0] o_string_source_index,
  output logic [31:0] o_string_dest_index,
  output logic o_interrupt_request,
  output logic o_debug_trap
);
  // ---------------------------------------------------------------
  // alu
  // ---------------------------------------------------------------
  pfl_alu_if alu_bus ();

  assign alu_bus.a = i_alu_a;
  assign alu_bus.b = i_alu_b;
  assign alu_bus.cin = i_alu_cin;
  assign alu_bus.op = i_alu_op;
  assign alu_bus.size = i_alu_size;

  pfl_alu u_alu (
    .bus(alu_bus)
  );

  // ---------------------------------------------------------------
  // interrupt pin synchroniser
  // ---------------------------------------------------------------
  logic [2:0] maskable_interrupt_pin_sync_q;
  logic [2:0] maskable_interrupt_pin_sync_d;
  logic maskable_interrupt_pin_level_q;
  logic maskable_interrupt_pin_level_d;

  always_comb begin
    maskable_interrupt_pin_sync_d = {maskable_interrupt_pin_sync_q[1:0], i_maskable_interrupt_pin};
    maskable_interrupt_pin_level_d = maskable_interrupt_pin_level_q;
    if (maskable_interrupt_pin_sync_q[2] == maskable_interrupt_pin_sync_q[1]) begin
      maskable_interrupt_pin_level_d = maskable_interrupt_pin_sync_q[2];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      maskable_interrupt_pin_sync_q <= 3'h0;
      maskable_interrupt_pin_level_q <= 1'b0;
    end else begin
      maskable_interrupt_pin_sync_q <= maskable_interrupt_pin_sync_d;
      maskable_interrupt_pin_level_q <= maskable_interrupt_pin_level_d;
    end
  end

  // ---------------------------------------------------------------
  // flag register
  // ---------------------------------------------------------------
  logic [31:0] flags_q;
  logic [31:0] flags_d;
  logic [31:0] img;
  logic priv_ok;

  always_comb begin
    flags_d = flags_q;
    img = i_load_image;
    priv_ok = (i_current_privilege_level <= flags_q[PFL_IOLVL_HI:PFL_IOLVL_LO]);
    case (i_load_kind)
      PFL_LD_POP: begin
        if (!priv_ok) begin
          img[PFL_IF_BIT] = flags_q[PFL_IF_BIT];
        end
        if (i_current_privilege_level != PFL_PRIV_KERNEL) begin
          img[PFL_IOLVL_HI:PFL_IOLVL_LO] = flags_q[PFL_IOLVL_HI:PFL_IOLVL_LO];
        end
        flags_d = (img & PFL_WRITE_MASK) | PFL_FIXED_ONES;
      end
      PFL_LD_TASK: begin
        flags_d = (img & PFL_WRITE_MASK) | PFL_FIXED_ONES;
      end
      PFL_LD_WRITE: begin
        img[PFL_IOLVL_HI:PFL_IOLVL_LO] = flags_q[PFL_IOLVL_HI:PFL_IOLVL_LO];
        img[PFL_IF_BIT] = flags_q[PFL_IF_BIT];
        flags_d = (img & PFL_WRITE_MASK) | PFL_FIXED_ONES;
      end
      default: begin
        if (i_alu_valid) begin
          flags_d = (flags_q & ~PFL_ARITH_MASK) | (alu_bus.flags & PFL_ARITH_MASK);
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      flags_q <= PFL_RESET_VALUE;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ---------------------------------------------------------------
  // string index stepping
  // ---------------------------------------------------------------
  logic [31:0] src_q;
  logic [31:0] src_d;
  logic [31:0] dst_q;
  logic [31:0] dst_d;
  logic [31:0] step;

  always_comb begin
    case (i_string_size)
      PFL_SZ8: step = PFL_STEP_1;
      PFL_SZ16: step = PFL_STEP_2;
      default: step = PFL_STEP_4;
    endcase
    src_d = src_q;
    dst_d = dst_q;
    if (i_string_step) begin
      if (flags_q[PFL_DIRECTION_BIT]) begin
        src_d = i_string_source_index - step;
        dst_d = i_string_dest_index - step;
      end else begin
        src_d = i_string_source_index + step;
        dst_d = i_string_dest_index + step;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      src_q <= 32'h0000_0000;
      dst_q <= 32'h0000_0000;
    end else begin
      src_q <= src_d;
      dst_q <= dst_d;
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  logic [31:0] res_q;
  logic [31:0] res_d;
  logic io_q;
  logic io_d;
  logic irq_q;
  logic irq_d;
  logic trap_q;
  logic trap_d;

  always_comb begin
    res_d = i_alu_valid ? alu_bus.result : res_q;
    io_d = !i_protected_mode ||
           (i_current_privilege_level <= flags_d[PFL_IOLVL_HI:PFL_IOLVL_LO]);
    irq_d = maskable_interrupt_pin_level_d && flags_d[PFL_IF_BIT];
    trap_d = 1'b0;
    if (i_insn_done) begin
      trap_d = flags_q[PFL_STEP_TRAP_BIT] || i_breakpoint_hit;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      res_q <= 32'h0000_0000;
      io_q <= 1'b0;
      irq_q <= 1'b0;
      trap_q <= 1'b0;
    end else begin
      res_q <= res_d;
      io_q <= io_d;
      irq_q <= irq_d;
      trap_q <= trap_d;
    end
  end

  assign o_processor_flags_register = flags_q;
  assign o_alu_result = res_q;
  assign o_io_allowed = io_q;
  assign o_string_source_index = src_q;
  assign o_string_dest_index = dst_q;
  assign o_interrupt_request = irq_q;
  assign o_debug_trap = trap_q;
endmodule : pfl_flags

// File: rtl/pfl_pkg.sv
// package: flag register layout, reset values and operation codes
package pfl_pkg;
  localparam int PFL_CARRY_BIT = 0;
  localparam int PFL_RSV1_BIT = 1;
  localparam int PFL_PARITY_BIT = 2;
  localparam int PFL_RSV3_BIT = 3;
  localparam int PFL_HALF_CARRY_BIT = 4;
  localparam int PFL_RSV5_BIT = 5;
  localparam int PFL_ZERO_BIT = 6;
  localparam int PFL_SIGN_BIT = 7;
  localparam int PFL_STEP_TRAP_BIT = 8;
  localparam int PFL_IF_BIT = 9;
  localparam int PFL_DIRECTION_BIT = 10;
  localparam int PFL_OVERFLOW_BIT = 11;
  localparam int PFL_IOLVL_LO = 12;
  localparam int PFL_IOLVL_HI = 13;
  localparam int PFL_HALF_BIT = 3;
  localparam logic [31:0] PFL_ARITH_MASK = 32'h0000_08d5;
  localparam logic [31:0] PFL_WRITE_MASK = 32'h0000_3fd5;
  localparam logic [31:0] PFL_FIXED_ONES = 32'h0000_0002;
  localparam logic [31:0] PFL_RESET_VALUE = 32'h0000_0002;
  localparam logic [1:0] PFL_PRIV_KERNEL = 2'h0;
  localparam logic [31:0] PFL_STEP_1 = 32'h0000_0001;
  localparam logic [31:0] PFL_STEP_2 = 32'h0000_0002;
  localparam logic [31:0] PFL_STEP_4 = 32'h0000_0004;

  typedef enum logic [1:0] {
    PFL_SZ8 = 2'h0,
    PFL_SZ16 = 2'h1,
    PFL_SZ32 = 2'h2
  } pfl_size_t;

  typedef enum logic [1:0] {
    PFL_OP_ADD = 2'h0,
    PFL_OP_SUB = 2'h1,
    PFL_OP_LOGIC = 2'h2
  } pfl_op_t;

  typedef enum logic [1:0] {
    PFL_LD_NONE = 2'h0,
    PFL_LD_POP = 2'h1,
    PFL_LD_TASK = 2'h3,
    PFL_LD_WRITE = 2'h2
  } pfl_load_t;
endpackage : pfl_pkg

// File: rtl/pfl_alu_if.sv
// interface: operands and computed flags between alu and flag register
`timescale 1ns/10ps
interface pfl_alu_if;
  import pfl_pkg::*;
  logic [31:0] a;
  logic [31:0] b;
  logic cin;
  pfl_op_t op;
  pfl_size_t size;
  logic [31:0] result;
  logic [31:0] flags;
  modport alu (input a, input b, input cin, input op, input size, output result, output flags);
  modport core (output a, output b, output cin, output op, output size, input result,
                input flags);
endinterface : pfl_alu_if

// File: rtl/pfl_alu.sv
// module: combinational result and arithmetic flag generation
`timescale 1ns/10ps
module pfl_alu
  import pfl_pkg::*;
(
  pfl_alu_if.alu bus
);
  logic [32:0] sum;
  logic [31:0] carries;
  logic [31:0] res;
  logic [31:0] bx;
  logic msb;
  logic c_in_msb;
  logic c_out;

  always_comb begin
    bx = (bus.op == PFL_OP_SUB) ? ~bus.b : bus.b;
    sum = {1'b0, bus.a} + {1'b0, bx} + {32'h0000_0000, (bus.op == PFL_OP_SUB) ^ bus.cin};
    carries = bus.a ^ bx ^ sum[31:0];
    res = (bus.op == PFL_OP_LOGIC) ? bus.b : sum[31:0];
    case (bus.size)
      PFL_SZ8: begin
        res = {24'h00_0000, res[7:0]};
        msb = res[7];
        c_in_msb = carries[7];
        c_out = carries[8];
      end
      PFL_SZ16: begin
        res = {16'h0000, res[15:0]};
        msb = res[15];
        c_in_msb = carries[15];
        c_out = carries[16];
      end
      default: begin
        msb = res[31];
        c_in_msb = carries[31];
        c_out = sum[32];
      end
    endcase
    bus.result = res;
    bus.flags = PFL_FIXED_ONES;
    if (bus.op != PFL_OP_LOGIC) begin
      bus.flags[PFL_CARRY_BIT] = c_out ^ (bus.op == PFL_OP_SUB);
      bus.flags[PFL_OVERFLOW_BIT] = c_in_msb ^ c_out;
      // subtract: carry into bit 4 is the inverse of the borrow
      bus.flags[PFL_HALF_CARRY_BIT] = carries[PFL_HALF_BIT + 1] ^ (bus.op == PFL_OP_SUB);
    end
    bus.flags[PFL_PARITY_BIT] = ~^res[7:0];
    bus.flags[PFL_ZERO_BIT] = (res == 32'h0000_0000);
    bus.flags[PFL_SIGN_BIT] = msb;
  end
endmodule : pfl_alu

// File: verif/pfl_flags_checker.sv
// checker: flag register timing and privilege assertions
`timescale 1ns/10ps
module pfl_flags_checker
  import pfl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_protected_mode,
  input wire logic [1:0] i_current_privilege_level,
  input wire logic i_alu_valid,
  input wire pfl_load_t i_load_kind,
  input wire logic [31:0] i_load_image,
  input wire logic i_insn_done,
  input wire logic i_breakpoint_hit,
  input wire logic [31:0] o_processor_flags_register,
  input wire logic [31:0] o_alu_result,
  input wire logic o_io_allowed,
  input wire logic o_interrupt_request,
  input wire logic o_debug_trap
);
  // ------------------------------
  // properties
  // ------------------------------
  wire [31:0] fl = o_processor_flags_register;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  rsvd_fixed_a: assert property (fl[5] == 1'h0 && fl[3] == 1'h0 && fl[1] == 1'h1)
    else $error("reserved flag bit moved");
  pop_level_a: assert property (i_load_kind == PFL_LD_POP &&
    i_current_privilege_level != PFL_PRIV_KERNEL |=> $stable(fl[13:12]))
    else $error("io level popped");
  if_guard_a: assert property (i_load_kind == PFL_LD_POP &&
    i_current_privilege_level > fl[13:12] |=> $stable(fl[9])) else $error("enable popped");
  task_level_a: assert property (i_load_kind == PFL_LD_TASK |=>
    fl[13:12] == $past(i_load_image[13:12])) else $error("task io level not loaded");
  io_perm_a: assert property (!$past(i_rst) |-> o_io_allowed ==
    (!$past(i_protected_mode) || $past(i_current_privilege_level) <= fl[13:12]))
    else $error("io permission wrong");
  step_trap_a: assert property (i_insn_done && fl[8] |=> o_debug_trap)
    else $error("step trap missing");
  bp_trap_a: assert property (!(i_insn_done && (fl[8] || i_breakpoint_hit)) |=>
    !o_debug_trap) else $error("spurious trap");
  int_mask_a: assert property (!fl[9] |-> !o_interrupt_request)
    else $error("masked interrupt seen");
  zero_flag_a: assert property (i_alu_valid && i_load_kind == PFL_LD_NONE |=>
    fl[6] == (o_alu_result == 32'h0000_0000)) else $error("zero flag wrong");
  pop_c: cover property (i_load_kind == PFL_LD_POP && i_current_privilege_level == 2'h0);
  task_c: cover property (i_load_kind == PFL_LD_TASK);
  trap_c: cover property (o_debug_trap);
endmodule : pfl_flags_checker
bind pfl_flags pfl_flags_checker u_chk (.*);

// File: verif/tb_top.sv
// testbench: self-checking bench for the flag register
`timescale 1ns/10ps
module tb_top;
  import pfl_pkg::*;
  typedef struct {pfl_op_t o; pfl_size_t s; logic [31:0] a, b; logic c; logic [31:0] r, f;} pfl_row_t;
  logic i_clk, i_rst, i_protected_mode, i_alu_valid, i_alu_cin, i_string_step;
  logic i_maskable_interrupt_pin, i_insn_done, i_breakpoint_hit;
  logic o_io_allowed, o_interrupt_request, o_debug_trap;
  logic [1:0] i_current_privilege_level;
  logic [31:0] i_alu_a, i_alu_b, i_load_image, i_string_source_index, i_string_dest_index;
  logic [31:0] o_processor_flags_register, o_alu_result;
  logic [31:0] o_string_source_index, o_string_dest_index;
  pfl_op_t i_alu_op;
  pfl_size_t i_alu_size, i_string_size;
  pfl_load_t i_load_kind;
  int miscompares, num_checks;
  pfl_row_t rows [8] = '{
    '{PFL_OP_ADD, PFL_SZ8, 32'h0000_007f, 32'h0000_0001, 1'h0, 32'h0000_0080, 32'h0000_0890},
    '{PFL_OP_ADD, PFL_SZ8, 32'h0000_00ff, 32'h0000_0001, 1'h0, 32'h0000_0000, 32'h0000_0055},
    '{PFL_OP_ADD, PFL_SZ16, 32'h0000_7fff, 32'h0000_0001, 1'h0, 32'h0000_8000, 32'h0000_0894},
    '{PFL_OP_SUB, PFL_SZ32, 32'h0000_0000, 32'h0000_0001, 1'h0, 32'hffff_ffff, 32'h0000_0095},
    '{PFL_OP_SUB, PFL_SZ8, 32'h0000_0080, 32'h0000_0000, 1'h1, 32'h0000_007f, 32'h0000_0810},
    '{PFL_OP_LOGIC, PFL_SZ32, 32'h0000_0005, 32'h0000_0000, 1'h0, 32'h0000_0000, 32'h0000_0044},
    '{PFL_OP_ADD, PFL_SZ16, 32'h0000_fffe, 32'h0000_0000, 1'h1, 32'h0000_ffff, 32'h0000_0084},
    '{PFL_OP_ADD, PFL_SZ32, 32'h8000_0000, 32'h8000_0000, 1'h0, 32'h0000_0000, 32'h0000_0845}};
  pfl_flags uut (.*);
  // ------------------------------
  // tasks
  // ------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic ld(input pfl_load_t k, input logic [31:0] im, input logic [1:0] current_privilege_level);
    @(posedge i_clk);
    i_load_kind <= k;
    i_load_image <= im;
    i_current_privilege_level <= current_privilege_level;
    @(posedge i_clk);
    i_load_kind <= PFL_LD_NONE;
    @(negedge i_clk);
  endtask : ld
  task automatic done(input logic bp, input logic e);
    @(posedge i_clk);
    i_insn_done <= 1'h1;
    i_breakpoint_hit <= bp;
    @(posedge i_clk);
    i_insn_done <= 1'h0;
    @(negedge i_clk);
    chk("trap", {31'h0, e}, {31'h0, o_debug_trap});
  endtask : done
  task automatic step(input pfl_size_t sz, input logic [31:0] es, input logic [31:0] ed);
    @(posedge i_clk);
    i_string_step <= 1'h1;
    i_string_size <= sz;
    @(posedge i_clk);
    i_string_step <= 1'h0;
    @(negedge i_clk);
    chk("src", es, o_string_source_index);
    chk("dst", ed, o_string_dest_index);
  endtask : step
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  // ------------------------------
  // stimulus
  // ------------------------------
  initial begin
    i_clk = 1'h0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    #30000;
    miscompares++;
    finish_test();
  end
  initial begin
    i_rst = 1'h1;
    {i_protected_mode, i_alu_valid, i_alu_cin, i_string_step} = 4'h0;
    {i_maskable_interrupt_pin, i_insn_done, i_breakpoint_hit} = 3'h0;
    {i_alu_a, i_alu_b, i_load_image} = '0;
    i_string_source_index = 32'h0000_0100;
    i_string_dest_index = 32'h0000_0200;
    i_current_privilege_level = 2'h0;
    i_alu_op = PFL_OP_ADD;
    i_alu_size = PFL_SZ8;
    i_string_size = PFL_SZ8;
    i_load_kind = PFL_LD_NONE;
    repeat (20) @(posedge i_clk);
    i_rst <= 1'h0;
    @(negedge i_clk);
    chk("reset", PFL_RESET_VALUE, o_processor_flags_register);
    foreach (rows[i]) begin
      @(posedge i_clk);
      i_alu_valid <= 1'h1;
      i_alu_op <= rows[i].o;
      i_alu_size <= rows[i].s;
      i_alu_a <= rows[i].a;
      i_alu_b <= rows[i].b;
      i_alu_cin <= rows[i].c;
      @(posedge i_clk);
      i_alu_valid <= 1'h0;
      @(negedge i_clk);
      chk("result", rows[i].r, o_alu_result);
      chk("arith", rows[i].f, o_processor_flags_register & PFL_ARITH_MASK);
    end
    $display("test alu table done");
    @(posedge i_clk);
    i_protected_mode <= 1'h1;
    ld(PFL_LD_POP, 32'h0000_322a, 2'h0);
    chk("pop", 32'h0000_3202, o_processor_flags_register);
    ld(PFL_LD_POP, 32'h0000_0000, 2'h1);
    chk("pop", 32'h0000_3002, o_processor_flags_register);
    ld(PFL_LD_TASK, 32'h0000_1200, 2'h3);
    chk("task", 32'h0000_1202, o_processor_flags_register);
    ld(PFL_LD_POP, 32'h0000_0000, 2'h3);
    chk("pop", 32'h0000_1202, o_processor_flags_register);
    chk("io", 32'h0, {31'h0, o_io_allowed});
    ld(PFL_LD_NONE, 32'h0000_0000, 2'h1);
    chk("io", 32'h1, {31'h0, o_io_allowed});
    $display("test privilege done");
    @(posedge i_clk);
    i_maskable_interrupt_pin <= 1'h1;
    repeat (8) @(negedge i_clk);
    chk("irq", 32'h1, {31'h0, o_interrupt_request});
    ld(PFL_LD_TASK, 32'h0000_0000, 2'h0);
    chk("irq", 32'h0, {31'h0, o_interrupt_request});
    ld(PFL_LD_WRITE, 32'h0000_3700, 2'h0);
    chk("write", 32'h0000_0502, o_processor_flags_register);
    $display("test interrupt done");
    done(1'h0, 1'h1);
    step(PFL_SZ32, 32'h0000_00fc, 32'h0000_01fc);
    ld(PFL_LD_WRITE, 32'h0000_0000, 2'h0);
    done(1'h0, 1'h0);
    done(1'h1, 1'h1);
    step(PFL_SZ16, 32'h0000_0102, 32'h0000_0202);
    step(PFL_SZ8, 32'h0000_0101, 32'h0000_0201);
    $display("test trap and string done");
    @(posedge i_clk);
    i_rst <= 1'h1;
    @(posedge i_clk);
    i_rst <= 1'h0;
    @(negedge i_clk);
    chk("reset", PFL_RESET_VALUE, o_processor_flags_register);
    chk("rst result", 32'h0, o_alu_result);
    chk("rst src", 32'h0, o_string_source_index);
    chk("rst io", 32'h0, {31'h0, o_io_allowed});
    @(negedge i_clk);
    chk("io", 32'h1, {31'h0, o_io_allowed});
    $display("test reset done");
    finish_test();
  end
endmodule : tb_top
